// >>> design/ceiu_pkg.sv
package ceiu_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses (one aligned 32-bit word each).
  // ----------------------------------------------------------------------
  localparam logic [7:0] CEIU_A_CMD = 8'h00;     // Event operation / result.
  localparam logic [7:0] CEIU_A_FLAGS = 8'h04;   // Sticky event flags, read only.
  localparam logic [7:0] CEIU_A_CT0 = 8'h08;     // Counter event 0 arm value.
  localparam logic [7:0] CEIU_A_CT1 = 8'h0c;     // Counter event 1 arm value.
  localparam logic [7:0] CEIU_A_CT2 = 8'h10;     // Counter event 2 arm value.
  localparam logic [7:0] CEIU_A_PMASK = 8'h14;   // Pin pattern mask.
  localparam logic [7:0] CEIU_A_PMATCH = 8'h18;  // Pin pattern value.
  localparam logic [7:0] CEIU_A_PMODE = 8'h1c;   // Bit 0: fire on mismatch.
  localparam logic [7:0] CEIU_A_SECFG = 8'h20;   // Four selectable event bytes.
  localparam logic [7:0] CEIU_A_ISRC = 8'h24;    // Three interrupt source bytes.
  localparam logic [7:0] CEIU_A_ICTL = 8'h28;    // Interrupt hold/permit/force/cancel.
  localparam logic [7:0] CEIU_A_BRK = 8'h2c;     // Remote breakpoint / status.
  localparam logic [7:0] CEIU_A_ISTAT = 8'h30;   // Sticky interrupt status.
  localparam logic [7:0] CEIU_A_ICLR = 8'h34;    // Write one to clear status.
  localparam logic [7:0] CEIU_A_IEN = 8'h38;     // Interrupt enable.
  localparam logic [7:0] CEIU_A_CNT = 8'h3c;     // System counter.
  localparam logic [7:0] CEIU_A_ATN = 8'h40;     // Attention strobe targets.

  // ----------------------------------------------------------------------
  // Event flag positions.
  // ----------------------------------------------------------------------
  localparam int CEIU_NEV = 16;
  localparam int CEIU_EV_ATN = 0;
  localparam int CEIU_EV_CT0 = 1;
  localparam int CEIU_EV_PAT = 4;
  localparam int CEIU_EV_SE0 = 5;
  localparam int CEIU_EV_FBW = 9;
  localparam int CEIU_EV_INT = 10;
  localparam int CEIU_EV_QMT = 11;
  localparam int CEIU_EV_XMT = 12;
  localparam int CEIU_EV_XFI = 13;
  localparam int CEIU_EV_XRO = 14;
  localparam int CEIU_EV_XRL = 15;

  // ----------------------------------------------------------------------
  // Field layouts and sizes.
  // ----------------------------------------------------------------------
  localparam int CEIU_NCT = 3;      // Counter events.
  localparam int CEIU_NSE = 4;      // Selectable events.
  localparam int CEIU_NCH = 3;      // Interrupt channels.
  localparam int CEIU_NSRC = 16;    // Selectable event source lines.
  localparam int CEIU_NCORE = 16;   // Cores reachable by strobes.
  localparam int CEIU_ICTL_HOLD = 0;
  localparam int CEIU_ICTL_PERMIT = 1;
  localparam int CEIU_ICTL_FORCE = 4;
  localparam int CEIU_ICTL_CANCEL = 8;
  localparam int CEIU_CMD_RES = 0;
  localparam int CEIU_CMD_BUSY = 1;
  localparam logic [31:0] CEIU_RST_WORD = 32'h0000_0000;

  // Operation codes carried in CMD bits [5:4]; bits [3:0] pick the event.
  typedef enum logic [1:0] {
    CEIU_OP_POLL = 2'b00,
    CEIU_OP_WAIT = 2'b01,
    CEIU_OP_BSET = 2'b10,
    CEIU_OP_BCLR = 2'b11
  } ceiu_op_t;

  // Selectable event condition, bits [6:5] of each configuration byte.
  typedef enum logic [1:0] {
    CEIU_SE_OFF = 2'b00,
    CEIU_SE_RISE = 2'b01,
    CEIU_SE_FALL = 2'b10,
    CEIU_SE_HIGH = 2'b11
  } ceiu_se_t;

  // Wait sequencer states.
  typedef enum logic [0:0] {
    CEIU_W_IDLE = 1'b0,
    CEIU_W_WAIT = 1'b1
  } ceiu_wst_t;

endpackage : ceiu_pkg

// >>> design/ceiu_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of independent levels.
module ceiu_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // First stage; read only by the second stage below.
  logic [W-1:0] meta_r;

  // --------------------------------------------------------------------
  // Synchroniser stages
  // --------------------------------------------------------------------
  // Each bit is resolved on its own, so multi-bit buses may tear by a cycle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : ceiu_sync

// >>> design/ceiu_top.sv
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
// Summary of operation
// - attention poll returns flag then clears it
// - three counter events armed by added delay
// - four selectable events, each own source
// - pin pattern match raises pattern flag
// - block-wrap poll returns and clears flag
// - interrupt-occurred poll returns and clears flag
// - four streamer conditions, separate flags, poll-clear
// - wait stalls until flag set, then clears
// - branch-if-set taken only when flag set
// - branch-if-clear taken only when flag clear
// - three interrupt channels, per-channel source select
// - forced trigger fires even while servicing held
// - breakpoint can be raised in any core
// - status word reports breakpoint and core state
module ceiu_top
  import ceiu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic atn_in,
  input wire logic brk_in,
  input wire logic [31:0] pins_in,
  input wire logic [CEIU_NSRC-1:0] se_src_in,
  input wire logic fifo_wrap_p,
  input wire logic solver_empty_p,
  input wire logic strm_empty_p,
  input wire logic strm_done_p,
  input wire logic strm_nco_p,
  input wire logic strm_lut_p,
  output logic [CEIU_NCORE-1:0] atn_out,
  output logic brk_out,
  output logic [3:0] brk_core_id,
  output logic [CEIU_NCH-1:0] int_fire,
  output logic core_stall,
  output logic irq
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic atn_s;                          // Synchronised attention line.
  logic brk_s;                          // Synchronised breakpoint request.
  logic [31:0] pins_s;                  // Synchronised pins.
  logic [CEIU_NSRC-1:0] src_s;          // Synchronised selectable sources.
  logic [CEIU_NSRC-1:0] src_d_r;        // Previous source levels.
  logic [CEIU_NEV-1:0] flags_r;         // Sticky event flags.
  logic [CEIU_NEV-1:0] ev_set;          // Raw events this cycle.
  logic [CEIU_NEV-1:0] ev_clr;          // Clears from polls and waits.
  logic [31:0] cnt_r;                   // Free-running system counter.
  logic [31:0] ct_tgt_r [CEIU_NCT];     // Counter trigger times.
  logic [CEIU_NCT-1:0] ct_arm_r;        // Counter event armed.
  logic [31:0] pmask_r;                 // Pattern mask.
  logic [31:0] pmatch_r;                // Pattern value.
  logic pmode_r;                        // High: fire on mismatch.
  logic pat_hit_r;                      // Pattern state last cycle.
  logic [31:0] secfg_r;                 // Selectable event configs.
  logic [23:0] isrc_r;                  // Interrupt source selects.
  logic hold_r;                         // Servicing held.
  logic [CEIU_NCH-1:0] pend_r;          // Pending triggers.
  logic [CEIU_NCH-1:0] force_r;         // Pending triggers that ignore the hold.
  logic brk_flag_r;                     // Breakpoint received.
  ceiu_wst_t wst_r;                     // Wait sequencer state.
  logic [3:0] widx_r;                   // Event being waited on.
  logic res_r;                          // Last poll or branch result.
  logic [CEIU_NEV-1:0] istat_r;         // Sticky interrupt status.
  logic [CEIU_NEV-1:0] ien_r;           // Interrupt enable.
  logic acc;                            // Bus access taken this cycle.
  logic wr;                             // Write taken this cycle.
  logic [31:0] wmask;                   // Byte lane mask.
  logic [31:0] rdata;                   // Read mux.

  // Merge written lanes into an old value; used by the CT, PMASK, PMATCH, SECFG, ISRC and IEN writes.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [31:0] m);
    merge = (o & ~m) | (n & m);
  endfunction : merge

  // Decode an interrupt source byte: zero is off, k picks event k-1.
  function automatic logic src_hit(input logic [7:0] s, input logic [CEIU_NEV-1:0] e);
    src_hit = (s != 8'h00) && (s <= 8'(CEIU_NEV)) && e[4'(s - 8'h01)];
  endfunction : src_hit

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  ceiu_sync #(.W(2 + 32 + CEIU_NSRC)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({atn_in, brk_in, pins_in, se_src_in}),
    .q({atn_s, brk_s, pins_s, src_s})
  );

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  // Classic cycle: one wait state, ack for a single cycle.
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Acknowledge every access, mapped or not; unmapped reads give zero.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= CEIU_RST_WORD;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? rdata : CEIU_RST_WORD;
    end
  end

  // Read multiplexer.
  always_comb begin
    case (wb_adr_i)
      CEIU_A_CMD: rdata = {30'h0, wst_r == CEIU_W_WAIT, res_r};
      CEIU_A_FLAGS: rdata = {16'h0, flags_r};
      CEIU_A_PMASK: rdata = pmask_r;
      CEIU_A_PMATCH: rdata = pmatch_r;
      CEIU_A_PMODE: rdata = {31'h0, pmode_r};
      CEIU_A_SECFG: rdata = secfg_r;
      CEIU_A_ISRC: rdata = {8'h0, isrc_r};
      CEIU_A_ICTL: rdata = {25'h0, force_r, pend_r, hold_r};
      // Breakpoint flag with core state beside it.
      CEIU_A_BRK: rdata = {10'h0, flags_r, pend_r, hold_r, core_stall, brk_flag_r};
      CEIU_A_ISTAT: rdata = {16'h0, istat_r};
      CEIU_A_IEN: rdata = {16'h0, ien_r};
      CEIU_A_CNT: rdata = cnt_r;
      default: rdata = CEIU_RST_WORD;
    endcase
  end

  // --------------------------------------------------------------------
  // System counter and counter events
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // Arming adds the written delay to the current count.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ct_arm_r <= '0;
      for (int i = 0; i < CEIU_NCT; i++) begin
        ct_tgt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < CEIU_NCT; i++) begin
        if (wr && wb_adr_i == CEIU_A_CT0 + 8'(4 * i)) begin
          ct_tgt_r[i] <= cnt_r + merge(32'h0, wb_dat_i, wmask);
          ct_arm_r[i] <= 1'b1;
        end else if (ct_arm_r[i] && cnt_r == ct_tgt_r[i]) begin
          ct_arm_r[i] <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Pattern, selectable and interrupt configuration
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pmask_r <= '0;
      pmatch_r <= '0;
      pmode_r <= 1'b0;
      secfg_r <= '0;
      isrc_r <= '0;
      ien_r <= '0;
    end else if (wr) begin
      case (wb_adr_i)
        CEIU_A_PMASK: pmask_r <= merge(pmask_r, wb_dat_i, wmask);
        CEIU_A_PMATCH: pmatch_r <= merge(pmatch_r, wb_dat_i, wmask);
        CEIU_A_PMODE: pmode_r <= wb_sel_i[0] ? wb_dat_i[0] : pmode_r;
        CEIU_A_SECFG: secfg_r <= merge(secfg_r, wb_dat_i, wmask);
        CEIU_A_ISRC: isrc_r <= 24'(merge({8'h0, isrc_r}, wb_dat_i, wmask));
        CEIU_A_IEN: ien_r <= 16'(merge({16'h0, ien_r}, wb_dat_i, wmask));
        default: pmode_r <= pmode_r;
      endcase
    end
  end

  // Pattern comparison is registered so the flag fires on entry only.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // The reset mask and value always match, so start in the match state
      // to keep a false pattern edge from following reset.
      pat_hit_r <= 1'b1;
      src_d_r <= '0;
    end else begin
      pat_hit_r <= ((pins_s & pmask_r) == pmatch_r) ^ pmode_r;
      src_d_r <= src_s;
    end
  end

  // --------------------------------------------------------------------
  // Raw event collection
  // --------------------------------------------------------------------
  always_comb begin
    ev_set = '0;
    ev_set[CEIU_EV_ATN] = atn_s;
    for (int i = 0; i < CEIU_NCT; i++) begin
      ev_set[CEIU_EV_CT0 + i] = ct_arm_r[i] && cnt_r == ct_tgt_r[i];
    end
    ev_set[CEIU_EV_PAT] = ((pins_s & pmask_r) == pmatch_r) ^ pmode_r && !pat_hit_r;
    // Each selectable event reads its own source and condition.
    for (int i = 0; i < CEIU_NSE; i++) begin
      case (ceiu_se_t'(secfg_r[8 * i + 5 +: 2]))
        CEIU_SE_RISE: ev_set[CEIU_EV_SE0 + i] =
            src_s[secfg_r[8 * i +: 4]] && !src_d_r[secfg_r[8 * i +: 4]];
        CEIU_SE_FALL: ev_set[CEIU_EV_SE0 + i] =
            !src_s[secfg_r[8 * i +: 4]] && src_d_r[secfg_r[8 * i +: 4]];
        CEIU_SE_HIGH: ev_set[CEIU_EV_SE0 + i] = src_s[secfg_r[8 * i +: 4]];
        default: ev_set[CEIU_EV_SE0 + i] = 1'b0;
      endcase
    end
    ev_set[CEIU_EV_FBW] = fifo_wrap_p;
    ev_set[CEIU_EV_INT] = |int_fire;
    ev_set[CEIU_EV_QMT] = solver_empty_p;
    ev_set[CEIU_EV_XMT] = strm_empty_p;
    ev_set[CEIU_EV_XFI] = strm_done_p;
    ev_set[CEIU_EV_XRO] = strm_nco_p;
    ev_set[CEIU_EV_XRL] = strm_lut_p;
  end

  // --------------------------------------------------------------------
  // Event operations: poll, wait and branch
  // --------------------------------------------------------------------
  // Polls clear the chosen flag; a finished wait clears its flag.
  always_comb begin
    ev_clr = '0;
    if (wr && wb_adr_i == CEIU_A_CMD && ceiu_op_t'(wb_dat_i[5:4]) == CEIU_OP_POLL) begin
      ev_clr[wb_dat_i[3:0]] = 1'b1;
    end
    if (wst_r == CEIU_W_WAIT && flags_r[widx_r]) begin
      ev_clr[widx_r] = 1'b1;
    end
  end

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= (flags_r & ~ev_clr) | ev_set;
    end
  end

  // Result bit: poll returns the flag, branches say whether taken.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      res_r <= 1'b0;
    end else if (wr && wb_adr_i == CEIU_A_CMD) begin
      case (ceiu_op_t'(wb_dat_i[5:4]))
        CEIU_OP_POLL: res_r <= flags_r[wb_dat_i[3:0]];
        CEIU_OP_BSET: res_r <= flags_r[wb_dat_i[3:0]];
        CEIU_OP_BCLR: res_r <= !flags_r[wb_dat_i[3:0]];
        default: res_r <= 1'b0;
      endcase
    end
  end

  // Wait sequencer; core_stall holds the pipeline until the flag shows.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wst_r <= CEIU_W_IDLE;
      widx_r <= '0;
      core_stall <= 1'b0;
    end else begin
      case (wst_r)
        CEIU_W_IDLE: begin
          if (wr && wb_adr_i == CEIU_A_CMD && ceiu_op_t'(wb_dat_i[5:4]) == CEIU_OP_WAIT) begin
            wst_r <= CEIU_W_WAIT;
            widx_r <= wb_dat_i[3:0];
            core_stall <= 1'b1;
          end
        end
        CEIU_W_WAIT: begin
          if (flags_r[widx_r]) begin
            wst_r <= CEIU_W_IDLE;
            core_stall <= 1'b0;
          end
        end
        default: begin
          wst_r <= CEIU_W_IDLE;
          core_stall <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Interrupt channels
  // --------------------------------------------------------------------
  // Servicing is permitted from reset; hold defers until permit.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_r <= 1'b0;
    end else if (wr && wb_adr_i == CEIU_A_ICTL && wb_dat_i[CEIU_ICTL_PERMIT]) begin
      hold_r <= 1'b0;
    end else if (wr && wb_adr_i == CEIU_A_ICTL && wb_dat_i[CEIU_ICTL_HOLD]) begin
      hold_r <= 1'b1;
    end
  end

  // A source event pends a channel; cancel wins over a same-cycle trigger
  // because a discard is the intent of the instruction.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_r <= '0;
      force_r <= '0;
      int_fire <= '0;
    end else begin
      for (int c = 0; c < CEIU_NCH; c++) begin
        int_fire[c] <= pend_r[c] && (!hold_r || force_r[c]);
        if (wr && wb_adr_i == CEIU_A_ICTL && wb_dat_i[CEIU_ICTL_CANCEL + c]) begin
          pend_r[c] <= 1'b0;
          force_r[c] <= 1'b0;
        end else if (wr && wb_adr_i == CEIU_A_ICTL && wb_dat_i[CEIU_ICTL_FORCE + c]) begin
          pend_r[c] <= 1'b1;
          force_r[c] <= 1'b1;
        end else if (src_hit(isrc_r[8 * c +: 8], ev_set)) begin
          pend_r[c] <= 1'b1;
        end else if (pend_r[c] && (!hold_r || force_r[c])) begin
          pend_r[c] <= 1'b0;
          force_r[c] <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Breakpoint and attention strobes
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      brk_out <= 1'b0;
      brk_core_id <= '0;
      atn_out <= '0;
    end else begin
      brk_out <= wr && wb_adr_i == CEIU_A_BRK && wb_sel_i[0];
      if (wr && wb_adr_i == CEIU_A_BRK && wb_sel_i[0]) begin
        brk_core_id <= wb_dat_i[3:0];
      end
      atn_out <= (wr && wb_adr_i == CEIU_A_ATN) ? 16'(wb_dat_i & wmask) : '0;
    end
  end

  // Incoming breakpoint sticks until software reads the status word.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      brk_flag_r <= 1'b0;
    end else if (brk_s) begin
      brk_flag_r <= 1'b1;
    end else if (acc && !wb_we_i && wb_adr_i == CEIU_A_BRK) begin
      brk_flag_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status, clear and enable
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      istat_r <= '0;
      irq <= 1'b0;
    end else begin
      if (wr && wb_adr_i == CEIU_A_ICLR) begin
        istat_r <= (istat_r & ~16'(wb_dat_i & wmask)) | ev_set;
      end else begin
        istat_r <= istat_r | ev_set;
      end
      irq <= |(istat_r & ien_r);
    end
  end

endmodule : ceiu_top

// >>> dv/ceiu_src_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Event source stand-in: a one-cycle request becomes a pulse.
// ------------------------------------------------------------
module ceiu_src_model (
  input wire logic ref_clk,
  input wire logic [5:0] req,
  output logic fifo_wrap_p,
  output logic solver_empty_p,
  output logic strm_empty_p,
  output logic strm_done_p,
  output logic strm_nco_p,
  output logic strm_lut_p
);
  // Registered so that every pulse leaves just after a clock edge.
  always_ff @(posedge ref_clk) begin
    {strm_lut_p, strm_nco_p, strm_done_p, strm_empty_p, solver_empty_p, fifo_wrap_p} <= req;
  end
endmodule : ceiu_src_model

// >>> dv/ceiu_top_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checks for the event and interrupt unit.
// ------------------------------------------------------------
module ceiu_top_checker
  import ceiu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic [CEIU_NCORE-1:0] atn_out,
  input logic brk_out,
  input logic [3:0] brk_core_id,
  input logic core_stall,
  input logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [CEIU_NCORE-1:0] atn_mask_r; // Last attention target mask.
  logic [3:0] brk_id_r; // Last breakpoint target.
  wire taken = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  sequence wr_to(logic [7:0] a);
    taken && wb_we_i && wb_adr_i == a;
  endsequence
  sequence wait_req;
    wr_to(CEIU_A_CMD) ##0 wb_dat_i[5:4] == CEIU_OP_WAIT;
  endsequence
  // Copies are kept so that the later pulse can be compared.
  always_ff @(posedge ref_clk) begin
    if (taken && wb_we_i && wb_adr_i == CEIU_A_ATN) begin
      atn_mask_r <= wb_dat_i[CEIU_NCORE-1:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (taken && wb_we_i && wb_adr_i == CEIU_A_BRK) begin
      brk_id_r <= wb_dat_i[3:0];
    end
  end
  ack_follows_a: assert property (taken |=> wb_ack_o)
    else $error("ack missing");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  atn_pulse_a: assert property (wr_to(CEIU_A_ATN) |-> ##[1:2] atn_out == atn_mask_r)
    else $error("attention targets wrong");
  atn_once_a: assert property (atn_out != '0 |=> atn_out == '0)
    else $error("attention pulse too long");
  brk_target_a: assert property (wr_to(CEIU_A_BRK) |-> ##[1:2] brk_out && brk_core_id == brk_id_r)
    else $error("breakpoint target wrong");
  wait_stall_a: assert property (wait_req |-> ##[1:2] core_stall)
    else $error("wait did not stall");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !irq && !core_stall && !wb_ack_o)
    else $error("outputs active in reset");
endmodule : ceiu_top_checker

bind ceiu_top ceiu_top_checker ceiu_top_checker_inst (
  .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .atn_out(atn_out), .brk_out(brk_out), .brk_core_id(brk_core_id),
  .core_stall(core_stall), .irq(irq)
);

// >>> dv/ceiu_top_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench for the event and interrupt unit.
// ------------------------------------------------------------
module ceiu_top_tb
  import ceiu_pkg::*;
;
  logic ref_clk = 1'b0, rst = 1'b1, cs = 1'b0, we = 1'b0, atn_in = 1'b0, brk_in = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, pins = 32'h0, rd, m, p;
  logic [15:0] se = 16'h0;
  logic [5:0] req = 6'h0;
  logic fifo_wrap_p, solver_empty_p, strm_empty_p, strm_done_p, strm_nco_p, strm_lut_p;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, brk_out, core_stall, irq;
  logic [3:0] brk_core_id;
  logic [CEIU_NCH-1:0] int_fire;
  logic [CEIU_NCORE-1:0] atn_out, atn_seen = '0;
  int failures = 0, checks = 0, fires = 0, fires2 = 0, n, id;
  int evq[$] = '{9, 11, 12, 13, 14, 15}; // Flag index of each model pulse line.
  always #2 ref_clk = ~ref_clk;
  // Pulses are counted and latched here since they stand one cycle.
  always @(posedge ref_clk) begin
    if (int_fire[0] === 1'b1) fires++;
    if (int_fire[2] === 1'b1) fires2++;
    if (atn_out != '0) atn_seen <= atn_out;
  end
  ceiu_src_model ceiu_src_model_inst (.ref_clk(ref_clk), .req(req),
    .fifo_wrap_p(fifo_wrap_p), .solver_empty_p(solver_empty_p), .strm_empty_p(strm_empty_p),
    .strm_done_p(strm_done_p), .strm_nco_p(strm_nco_p), .strm_lut_p(strm_lut_p));
  ceiu_top ceiu_top_inst (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cs), .wb_stb_i(cs),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .atn_in(atn_in), .brk_in(brk_in), .pins_in(pins), .se_src_in(se),
    .fifo_wrap_p(fifo_wrap_p), .solver_empty_p(solver_empty_p), .strm_empty_p(strm_empty_p),
    .strm_done_p(strm_done_p), .strm_nco_p(strm_nco_p), .strm_lut_p(strm_lut_p),
    .atn_out(atn_out), .brk_out(brk_out), .brk_core_id(brk_core_id), .int_fire(int_fire),
    .core_stall(core_stall), .irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : tick
  // One classic cycle; the request is held until ack is sampled.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    cs <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    cs <= 1'b0;
    if (k >= 20) begin
      failures++;
      complete_run();
    end
  endtask : bus
  task automatic pulse(input int b);
    @(posedge ref_clk);
    req <= 6'(1 << b);
    @(posedge ref_clk);
    req <= 6'h0;
  endtask : pulse
  task automatic op(input ceiu_op_t o, input int e, input logic exp);
    bus(1'b1, CEIU_A_CMD, {26'h0, o, e[3:0]});
    bus(1'b0, CEIU_A_CMD, 32'h0);
    chk(rd[0], exp);
  endtask : op
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h5452c38e));
    tick(6);
    rst <= 1'b0;
    tick(1);
    bus(1'b0, 8'h7c, 32'h0);
    chk(rd, 32'h0);
    foreach (evq[i]) begin
      op(CEIU_OP_BSET, evq[i], 1'b0);
      pulse(i);
      tick(2);
      bus(1'b0, CEIU_A_FLAGS, 32'h0);
      chk(rd[evq[i]], 1'b1);
      op(CEIU_OP_BCLR, evq[i], 1'b0);
      op(CEIU_OP_POLL, evq[i], 1'b1);
      op(CEIU_OP_POLL, evq[i], 1'b0);
    end
    atn_in <= 1'b1;
    tick(4);
    atn_in <= 1'b0;
    tick(4);
    op(CEIU_OP_POLL, CEIU_EV_ATN, 1'b1);
    op(CEIU_OP_POLL, CEIU_EV_ATN, 1'b0);
    m = $urandom | 32'h1;
    bus(1'b1, CEIU_A_ATN, m);
    tick(2);
    chk(atn_seen, m[15:0]);
    bus(1'b1, CEIU_A_CT0, 32'd40);
    bus(1'b1, CEIU_A_CMD, {26'h0, CEIU_OP_WAIT, 4'h1});
    tick(1);
    n = 0;
    while (core_stall === 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100) begin
      failures++;
      complete_run();
    end
    chk(n >= 20 && n <= 40, 1'b1);
    bus(1'b0, CEIU_A_FLAGS, 32'h0);
    chk(rd[CEIU_EV_CT0], 1'b0);
    p = $urandom & 32'hff;
    pins <= ~p;
    bus(1'b1, CEIU_A_PMASK, 32'hff);
    bus(1'b1, CEIU_A_PMATCH, p);
    bus(1'b1, CEIU_A_PMODE, 32'h0);
    op(CEIU_OP_BSET, CEIU_EV_PAT, 1'b0);
    pins <= p;
    tick(6);
    op(CEIU_OP_BSET, CEIU_EV_PAT, 1'b1);
    bus(1'b1, CEIU_A_SECFG, 32'h2322_2120);
    se <= 16'hf;
    tick(6);
    bus(1'b0, CEIU_A_FLAGS, 32'h0);
    chk(rd[CEIU_EV_SE0+:4], 4'hf);
    bus(1'b1, CEIU_A_ISRC, 32'h0000_000a);
    pulse(0);
    tick(8);
    chk(fires, 1);
    bus(1'b1, CEIU_A_ICTL, 32'h1);
    pulse(0);
    tick(8);
    chk(fires, 1);
    bus(1'b1, CEIU_A_ICTL, 32'h11);
    tick(8);
    chk(fires, 2);
    pulse(0);
    tick(2);
    bus(1'b1, CEIU_A_ICTL, 32'h101);
    bus(1'b1, CEIU_A_ICTL, 32'h2);
    tick(8);
    chk(fires, 2);
    op(CEIU_OP_POLL, CEIU_EV_INT, 1'b1);
    op(CEIU_OP_POLL, CEIU_EV_INT, 1'b0);
    bus(1'b1, CEIU_A_ISRC, 32'h000a_0000);
    pulse(0);
    tick(8);
    chk(fires2, 1);
    chk(fires, 2);
    bus(1'b1, CEIU_A_IEN, 32'hffff_ffff);
    bus(1'b1, CEIU_A_ICLR, 32'hffff_ffff);
    tick(3);
    chk(irq, 1'b0);
    pulse(3);
    tick(4);
    chk(irq, 1'b1);
    bus(1'b1, CEIU_A_IEN, 32'h0);
    tick(3);
    chk(irq, 1'b0);
    id = $urandom % 16;
    bus(1'b1, CEIU_A_BRK, id);
    tick(2);
    chk(brk_core_id, id[3:0]);
    brk_in <= 1'b1;
    tick(4);
    brk_in <= 1'b0;
    tick(4);
    bus(1'b0, CEIU_A_BRK, 32'h0);
    chk(rd[1:0], 2'b01);
    bus(1'b0, CEIU_A_BRK, 32'h0);
    chk(rd[0], 1'b0);
    complete_run();
  end
endmodule : ceiu_top_tb
